/* cmc_ctrl.sv */
`timescale 1ns/1ns
// Contract
// R1: eight comparator modes selected by a three-bit field in the control register
// R2: comparator outputs read at control bits 7:6, writes ignored there
// R3: mode 110 drives pins three and four with raw comparator outputs
// R4: direction bits still enable pin drivers while outputs are routed
// R5: direction register sets comparator pin direction in every mode
// R6: port reads return zero on pins that the mode makes analog
// R7: flag bit six set when either output differs from its reference
// R8: software clears flag by writing zero; writing one sets it
// R9: request reaches core only with change, peripheral and global enables set
// R10: flag still sets when any enable is clear
// R11: change coinciding with control read may be missed; not replicated here
// R12: any control register access reloads reference, ending mismatch
// R13: flag keeps setting while mismatch lasts
// R14: comparators run in sleep; enabled interrupt wakes device
// R15: mode 111 powers both comparators off
// R16: wake from sleep keeps control register unchanged
// R17: reset returns control register to zero, mode 000 all analog; the code makes pins zero to three analog and keeps pin four digital
// R18: comparators held powered down while reset asserted
// R19: software disables the interrupt while changing modes
// R20: synchronised outputs compared each cycle against reference latch
// R21: pin mapping for middle modes is a configurable decode table
module cmc_ctrl
  import cmc_pkg::*;
#(
  parameter logic [31:0] ANALOG_MAP = CMC_ANALOG_MAP_DEF
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // avalon-mm slave
  input wire logic [CMC_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // analog comparator side
  input wire logic [1:0] cmp_raw_in,
  output logic [2:0] cmp_mode_out,
  output logic cmp_power_out,
  // port a pins
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_out,
  // core
  output logic irq_out,
  output logic wake_out
);
  cmc_req_type req;
  logic [7:0] intctl_r;
  logic [4:0] tris_r;
  logic [5:0] cmctl_r;
  logic flag_r;
  logic cen_r;
  logic [4:0] platch_r;
  logic sleep_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] ref_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [4:0] pin_r;
  logic [4:0] oe_r;
  logic irq_r;
  logic wake_r;
  logic [2:0] mode_r;
  logic pwr_r;

  // mode zero must leave every comparator pin analog
  if (ANALOG_MAP[3:0] != 4'hF) begin : g_map_check
    $error("analog map must make every pin analog in mode zero");
  end

  assign req = '{rd: avs_read_in, wr: avs_write_in, addr: avs_address_in,
                 wdata: avs_writedata_in[7:0]};

  wire acc = (req.rd | req.wr) & wait_r & ce_in;
  wire wr_go = acc & req.wr;
  wire hit_int = req.addr == CMC_ADDR_INTCTL;
  wire hit_tris = req.addr == CMC_ADDR_TRIS;
  wire hit_cm = req.addr == CMC_ADDR_CMCTL;
  wire hit_pf = req.addr == CMC_ADDR_PFLAG;
  wire hit_pe = req.addr == CMC_ADDR_PEN;
  wire hit_pa = req.addr == CMC_ADDR_PORTA;
  wire hit_pl = req.addr == CMC_ADDR_PLATCH;
  wire hit_sl = req.addr == CMC_ADDR_SLEEP;
  wire [2:0] mode = cmctl_r[2:0];
  wire cm_touch = acc & hit_cm; // R12
  wire mismatch = sync2_r != ref_r; // R20 R11
  wire flag_wr = wr_go & hit_pf;
  // set wins over a software clear
  wire flag_nxt = mismatch | (flag_wr ? req.wdata[CMC_FLAG_BIT] : flag_r); // R7 R8 R10 R13
  // analog pins for the current mode, pin four always digital
  wire [3:0] analog = ANALOG_MAP[{mode, 2'b00} +: 4]; // R21 R17
  wire [4:0] pin_rd = pin_in & ~{1'b0, analog}; // R6
  wire route = mode == CMC_MODE_PINOUT;
  wire [4:0] drive = route ? {cmp_raw_in[1], cmp_raw_in[0], platch_r[2:0]} : platch_r; // R3
  wire [7:0] cm_view = {sync2_r[1], sync2_r[0], cmctl_r}; // R2
  wire irq_nxt = flag_r & cen_r & intctl_r[CMC_PERIPH_EN_BIT] & intctl_r[CMC_GLOBAL_EN_BIT]; // R9
  wire wake_nxt = sleep_r & flag_r & cen_r; // R14
  wire pwr_nxt = mode != CMC_MODE_OFF; // R15 R1

  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    if (hit_int) rsel = {intctl_r[7:1], 1'b0};
    if (hit_tris) rsel = {3'h0, tris_r};
    if (hit_cm) rsel = cm_view;
    if (hit_pf) rsel = {1'b0, flag_r, 6'h00};
    if (hit_pe) rsel = {1'b0, cen_r, 6'h00};
    if (hit_pa) rsel = {3'h0, pin_rd};
    if (hit_pl) rsel = {3'h0, platch_r};
    if (hit_sl) rsel = {7'h00, sleep_r};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      intctl_r <= CMC_INTCTL_RST;
      tris_r <= CMC_TRIS_RST;
      cmctl_r <= CMC_CMCTL_RST; // R17
      flag_r <= 1'b0;
      cen_r <= 1'b0;
      platch_r <= CMC_PLATCH_RST;
      sleep_r <= 1'b0;
    end else if (ce_in) begin
      if (wr_go & hit_int) intctl_r <= req.wdata;
      if (wr_go & hit_tris) tris_r <= req.wdata[4:0];
      if (wr_go & hit_cm) cmctl_r <= req.wdata[5:0]; // R1 R16
      if (wr_go & hit_pe) cen_r <= req.wdata[CMC_CEN_BIT];
      if (wr_go & hit_pl) platch_r <= req.wdata[4:0];
      if (wr_go & hit_sl) sleep_r <= req.wdata[0];
      else if (wake_r) sleep_r <= 1'b0;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      ref_r <= 2'h0;
    end else if (ce_in) begin
      sync1_r <= cmp_raw_in;
      sync2_r <= sync1_r;
      if (cm_touch) ref_r <= sync2_r; // R12
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      wait_r <= ~acc;
      if (acc & req.rd) rdata_r <= {24'h000000, rsel};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_r <= 5'h00;
      oe_r <= 5'h00;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      mode_r <= CMC_MODE_RESET;
      pwr_r <= 1'b0; // R18
    end else if (ce_in) begin
      pin_r <= drive;
      oe_r <= ~tris_r; // R4 R5
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      mode_r <= mode;
      pwr_r <= pwr_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign pin_out = pin_r;
  assign pin_oe_out = oe_r;
  assign irq_out = irq_r;
  assign wake_out = wake_r;
  assign cmp_mode_out = mode_r;
  assign cmp_power_out = pwr_r;

  property p_flag_set;
    @(posedge clk_in) disable iff (rst_in) ce_in && mismatch |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R7

  property p_clear;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && flag_wr && !req.wdata[CMC_FLAG_BIT] && !mismatch |=> !flag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // R8

  property p_ref;
    @(posedge clk_in) disable iff (rst_in) cm_touch |=> ref_r == $past(sync2_r);
  endproperty
  a_ref: assert property (p_ref) else $error("reference not reloaded"); // R12

  property p_irq;
    @(posedge clk_in) disable iff (rst_in) irq_out |-> $past(flag_r) && $past(cen_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable"); // R9

  property p_off;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && mode == CMC_MODE_OFF |=> !cmp_power_out;
  endproperty
  a_off: assert property (p_off) else $error("comparators not off"); // R15

  property p_route;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && route |=> pin_out[CMC_PIN4] == $past(cmp_raw_in[1]);
  endproperty
  a_route: assert property (p_route) else $error("pin not routed"); // R3

  property p_oe;
    @(posedge clk_in) disable iff (rst_in) ce_in |=> pin_oe_out == ~$past(tris_r);
  endproperty
  a_oe: assert property (p_oe) else $error("direction ignored"); // R4

  sequence s_req;
    acc && req.rd && hit_pa;
  endsequence
  property p_analog;
    @(posedge clk_in) disable iff (rst_in)
      s_req ##0 (mode == CMC_MODE_RESET) |=> rdata_r[3:0] == 4'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin read nonzero"); // R6

  property p_flag_soft;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && flag_wr && req.wdata[CMC_FLAG_BIT] |=> flag_r;
  endproperty
  a_flag_soft: assert property (p_flag_soft) else $error("flag not set by write"); // R8

  property p_set_wins;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && flag_wr && mismatch |=> flag_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat mismatch"); // R13

  property p_flag_hold;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !flag_wr && !mismatch |=> flag_r == $past(flag_r);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed unprompted"); // R7

  property p_flag_no_en;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && mismatch && !cen_r |=> flag_r;
  endproperty
  a_flag_no_en: assert property (p_flag_no_en) else $error("flag gated by enable"); // R10

  property p_irq_on;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && flag_r && cen_r && intctl_r[CMC_PERIPH_EN_BIT] && intctl_r[CMC_GLOBAL_EN_BIT]
      |=> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled irq missing"); // R9

  property p_irq_gie;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !intctl_r[CMC_GLOBAL_EN_BIT] |=> !irq_out;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable"); // R9

  property p_ref_hold;
    @(posedge clk_in) disable iff (rst_in)
      !cm_touch |=> $stable(ref_r);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference moved"); // R12

  property p_sync;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> sync2_r == $past(sync1_r);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser skipped"); // R20

  property p_match_end;
    @(posedge clk_in) disable iff (rst_in)
      cm_touch && sync1_r == sync2_r |=> !mismatch;
  endproperty
  a_match_end: assert property (p_match_end) else $error("mismatch not ended"); // R12

  property p_mode_out;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> cmp_mode_out == $past(cmctl_r[2:0]);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output wrong"); // R1

  property p_power_on;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !rst_in && mode != CMC_MODE_OFF |=> cmp_power_out;
  endproperty
  a_power_on: assert property (p_power_on) else $error("comparators not powered"); // R15

  property p_cm_write;
    @(posedge clk_in) disable iff (rst_in)
      wr_go && hit_cm |=> cmctl_r == $past(req.wdata[5:0]);
  endproperty
  a_cm_write: assert property (p_cm_write) else $error("control write lost"); // R1 R16

  property p_cm_read;
    @(posedge clk_in) disable iff (rst_in)
      acc && req.rd && hit_cm |=> rdata_r[7:0] == {$past(sync2_r), $past(cmctl_r)};
  endproperty
  a_cm_read: assert property (p_cm_read) else $error("control read wrong"); // R2

  property p_pin3;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && route |=> pin_out[CMC_PIN3] == $past(cmp_raw_in[0]);
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin three not routed"); // R3

  property p_latch;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !route |=> pin_out == $past(platch_r);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not on pins"); // R3

  property p_analog_any;
    @(posedge clk_in) disable iff (rst_in)
      s_req |=> (rdata_r[3:0] & $past(analog)) == 4'h0;
  endproperty
  a_analog_any: assert property (p_analog_any) else $error("analog pin read set"); // R6

  property p_pin4_dig;
    @(posedge clk_in) disable iff (rst_in)
      s_req |=> rdata_r[CMC_PIN4] == $past(pin_in[CMC_PIN4]);
  endproperty
  a_pin4_dig: assert property (p_pin4_dig) else $error("pin four read wrong"); // R6

  property p_wake_on;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && sleep_r && flag_r && cen_r |=> wake_out;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("no wake"); // R14

  property p_wake_ends;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && wake_r && !(wr_go && hit_sl) |=> !sleep_r;
  endproperty
  a_wake_ends: assert property (p_wake_ends) else $error("sleep not left"); // R14

  property p_rst_off;
    @(posedge clk_in)
      rst_in |=> !cmp_power_out && cmp_mode_out == CMC_MODE_RESET;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("comparators live in reset"); // R18 R17

  property p_tris_write;
    @(posedge clk_in) disable iff (rst_in)
      wr_go && hit_tris |=> tris_r == $past(req.wdata[4:0]);
  endproperty
  a_tris_write: assert property (p_tris_write) else $error("direction write lost"); // R5

  property p_wait_ans;
    @(posedge clk_in) disable iff (rst_in)
      acc |=> !avs_waitrequest_out;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");

  property p_wait_one;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer stood too long");

  property p_freeze;
    @(posedge clk_in) disable iff (rst_in)
      !ce_in |=> $stable(cmctl_r) && $stable(flag_r) && $stable(ref_r)
      && $stable(avs_waitrequest_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : cmc_ctrl

/* cmc_pkg.sv */
package cmc_pkg;
  // register byte address is the register index times four
  localparam logic [7:0] CMC_IDX_INTCTL = 8'h0B;
  localparam logic [7:0] CMC_IDX_TRIS = 8'h85;
  localparam logic [7:0] CMC_IDX_CMCTL = 8'h1F;
  localparam logic [7:0] CMC_IDX_PFLAG = 8'h0C;
  localparam logic [7:0] CMC_IDX_PEN = 8'h8C;
  localparam logic [7:0] CMC_IDX_PORTA = 8'h05;
  localparam logic [7:0] CMC_IDX_PLATCH = 8'h40;
  localparam logic [7:0] CMC_IDX_SLEEP = 8'h41;
  localparam int CMC_AW = 10;
  localparam logic [9:0] CMC_ADDR_INTCTL = {CMC_IDX_INTCTL, 2'b00};
  localparam logic [9:0] CMC_ADDR_TRIS = {CMC_IDX_TRIS, 2'b00};
  localparam logic [9:0] CMC_ADDR_CMCTL = {CMC_IDX_CMCTL, 2'b00};
  localparam logic [9:0] CMC_ADDR_PFLAG = {CMC_IDX_PFLAG, 2'b00};
  localparam logic [9:0] CMC_ADDR_PEN = {CMC_IDX_PEN, 2'b00};
  localparam logic [9:0] CMC_ADDR_PORTA = {CMC_IDX_PORTA, 2'b00};
  localparam logic [9:0] CMC_ADDR_PLATCH = {CMC_IDX_PLATCH, 2'b00};
  localparam logic [9:0] CMC_ADDR_SLEEP = {CMC_IDX_SLEEP, 2'b00};
  // field positions
  localparam int CMC_OUT1_BIT = 6;
  localparam int CMC_OUT2_BIT = 7;
  localparam int CMC_FLAG_BIT = 6;
  localparam int CMC_CEN_BIT = 6;
  localparam int CMC_PERIPH_EN_BIT = 6;
  localparam int CMC_GLOBAL_EN_BIT = 7;
  localparam int CMC_PIN3 = 3;
  localparam int CMC_PIN4 = 4;
  // reset values
  localparam logic [7:0] CMC_INTCTL_RST = 8'h00;
  localparam logic [4:0] CMC_TRIS_RST = 5'h1F;
  localparam logic [5:0] CMC_CMCTL_RST = 6'h00;
  localparam logic [4:0] CMC_PLATCH_RST = 5'h00;
  // modes
  localparam logic [2:0] CMC_MODE_RESET = 3'h0;
  localparam logic [2:0] CMC_MODE_PINOUT = 3'h6;
  localparam logic [2:0] CMC_MODE_OFF = 3'h7;
  // analog mask, one nibble per mode for pins zero to three, mid modes configurable
  localparam logic [31:0] CMC_ANALOG_MAP_DEF = 32'hF00F_FFFF;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } cmc_req_type;
endpackage : cmc_pkg

/* cmc_cmp_model.sv */
`timescale 1ns/1ns
module cmc_cmp_model
  import cmc_pkg::*;
(
  // bench commands
  input wire logic [1:0] level_in,
  input wire logic [4:0] ext_in,
  // design side
  input wire logic power_in,
  input wire logic [4:0] pin_drv_in,
  input wire logic [4:0] pin_oe_in,
  output logic [1:0] cmp_raw_out,
  output logic [4:0] pin_level_out
);
  // unpowered comparators give no valid level
  assign cmp_raw_out = power_in ? level_in : 2'h0;
  // driven pins follow the design, others the outside world
  assign pin_level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_in);
endmodule : cmc_cmp_model

/* test_cmc_ctrl.sv */
`timescale 1ns/1ns
module test_cmc_ctrl;
  import cmc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] lvl = 2'h0;
  logic [4:0] ext = 5'h00;
  logic [1:0] raw;
  logic [2:0] mode;
  logic pwr, irq, wake;
  logic [4:0] pins, pout, poe;
  logic [7:0] q;
  logic ce = 1'b1;
  logic woke = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk_in = ~clk_in;
  // wake stands two cycles only
  always @(posedge clk_in) if (wake) woke <= 1'b1;
  cmc_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .cmp_raw_in(raw), .cmp_mode_out(mode), .cmp_power_out(pwr),
    .pin_in(pins), .pin_out(pout), .pin_oe_out(poe), .irq_out(irq), .wake_out(wake));
  cmc_cmp_model far (.level_in(lvl), .ext_in(ext), .power_in(pwr), .pin_drv_in(pout),
    .pin_oe_in(poe), .cmp_raw_out(raw), .pin_level_out(pins));
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one avalon access, held until waitrequest is seen low
  task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : acc
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    ext <= 5'h1F;
    repeat (4) @(posedge clk_in);
    acc(0, CMC_ADDR_CMCTL, 0);
    check("control", q, 8'h00);
    acc(0, CMC_ADDR_TRIS, 0);
    check("direction", q, 8'h1F);
    check("power", {7'h0, pwr}, 8'h01);
    acc(0, CMC_ADDR_PORTA, 0);
    check("port", q, 8'h10);
    $display("test reset done");
    lvl <= 2'h1;
    acc(1, CMC_ADDR_CMCTL, 8'hC6);
    acc(0, CMC_ADDR_CMCTL, 0);
    check("control", q, 8'h46);
    check("mode", {5'h0, mode}, 8'h06);
    acc(1, CMC_ADDR_TRIS, 8'h00);
    repeat (3) @(posedge clk_in);
    check("oe", {3'h0, poe}, 8'h1F);
    check("pins", {6'h0, pout[4:3]}, 8'h01);
    acc(1, CMC_ADDR_TRIS, 8'h08);
    repeat (3) @(posedge clk_in);
    check("oe", {3'h0, poe}, 8'h17);
    ce <= 1'b0;
    lvl <= 2'h2;
    repeat (4) @(posedge clk_in);
    check("frozen pins", {6'h0, pout[4:3]}, 8'h01);
    ce <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("pins", {6'h0, pout[4:3]}, 8'h02);
    lvl <= 2'h1;
    repeat (4) @(posedge clk_in);
    $display("test routing done");
    acc(1, CMC_ADDR_PEN, 8'h40);
    acc(1, CMC_ADDR_INTCTL, 8'hC0);
    acc(0, CMC_ADDR_CMCTL, 0);
    acc(1, CMC_ADDR_PFLAG, 8'h00);
    lvl <= 2'h2;
    repeat (8) @(posedge clk_in);
    check("irq", {7'h0, irq}, 8'h01);
    acc(0, CMC_ADDR_PFLAG, 0);
    check("flag", q & 8'h40, 8'h40);
    acc(1, CMC_ADDR_PFLAG, 8'h00);
    acc(0, CMC_ADDR_PFLAG, 0);
    check("flag", q & 8'h40, 8'h40);
    acc(0, CMC_ADDR_CMCTL, 0);
    acc(1, CMC_ADDR_PFLAG, 8'h00);
    acc(0, CMC_ADDR_PFLAG, 0);
    check("flag", q & 8'h40, 8'h00);
    acc(1, CMC_ADDR_PFLAG, 8'h40);
    acc(0, CMC_ADDR_PFLAG, 0);
    check("flag", q & 8'h40, 8'h40);
    acc(1, CMC_ADDR_PFLAG, 8'h00);
    acc(1, CMC_ADDR_INTCTL, 8'h00);
    lvl <= 2'h1;
    repeat (8) @(posedge clk_in);
    check("irq", {7'h0, irq}, 8'h00);
    acc(0, CMC_ADDR_PFLAG, 0);
    check("flag", q & 8'h40, 8'h40);
    $display("test change done");
    acc(0, CMC_ADDR_CMCTL, 0);
    acc(1, CMC_ADDR_PFLAG, 8'h00);
    acc(1, CMC_ADDR_SLEEP, 8'h01);
    check("wake", {7'h0, woke}, 8'h00);
    lvl <= 2'h3;
    repeat (8) @(posedge clk_in);
    check("wake", {7'h0, woke}, 8'h01);
    acc(0, CMC_ADDR_SLEEP, 0);
    check("sleep", q, 8'h00);
    acc(0, CMC_ADDR_CMCTL, 0);
    check("control", q, 8'hC6);
    acc(1, CMC_ADDR_CMCTL, 8'h07);
    check("power", {7'h0, pwr}, 8'h00);
    acc(1, CMC_ADDR_CMCTL, 8'h06);
    check("power", {7'h0, pwr}, 8'h01);
    $display("test sleep done");
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("power", {7'h0, pwr}, 8'h00);
    check("mode", {5'h0, mode}, 8'h00);
    rst_in <= 1'b0;
    @(posedge clk_in);
    acc(0, CMC_ADDR_CMCTL, 0);
    check("control", q & 8'h3F, 8'h00);
    $display("test reset again done");
    give_verdict();
  end
endmodule : test_cmc_ctrl
